// ==== pmtc_core.v ====
/*
 * Prescaled match timer core: run control, main counter, divider tally, four
 * compare channels with flag, clear and stop actions, and the register port.
 * Assumes one clock, a synchronous active-high reset and a register port whose
 * strobes last one cycle and are synchronous to the clock.
 */
`timescale 1ns/1ns
`include "pmtc_regs.vh"

module pmtc_core #(
  parameter W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [31:0] reg_addr,
  input wire reg_wr_en,
  input wire [31:0] reg_wr_data,
  input wire reg_rd_en,
  output wire [31:0] reg_rd_data,
  // Status
  output wire [3:0] event_flags,
  output wire count_running
);

  localparam NCH = `PMTC_NUM_CHAN;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Compares a register address with one target address.
  function addr_is;
    input [31:0] addr;
    input [31:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Widens a counter value to the register port width.
  function [31:0] zext;
    input [W-1:0] value;
    begin
      zext = 32'h0000_0000;
      zext[W-1:0] = value;
    end
  endfunction

  // Picks one action enable of one channel out of the compare action field.
  function act_bit;
    input [`PMTC_ACT_USED_W-1:0] action;
    input integer chan;
    input integer ofs;
    begin
      act_bit = action[chan*`PMTC_ACT_STRIDE + ofs];
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [3:0] flag_ff;
  reg [3:0] nxt_flag;
  reg [1:0] run_ff;
  reg [1:0] nxt_run;
  reg [W-1:0] counter_ff;
  reg [W-1:0] nxt_counter;
  reg [W-1:0] limit_ff;
  reg [`PMTC_ACT_USED_W-1:0] action_ff;
  reg [W-1:0] cmp_value_ff [0:NCH-1];
  reg [31:0] rd_data_ff;
  reg [31:0] nxt_rd_data;
  integer k;

  wire wr_flag = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_EVENT_FLAG);
  wire wr_run = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_RUN_CONTROL);
  wire wr_counter = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_MAIN_COUNTER);
  wire wr_limit = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_DIVIDER_LIMIT);
  wire wr_tally = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_DIVIDER_TALLY);
  wire wr_action = reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_COMPARE_ACTION);

  // ****************************************************************
  // Compare channels
  // ****************************************************************
  wire [NCH-1:0] hit;
  wire [NCH-1:0] hit_event;
  wire [NCH-1:0] irq_en;
  wire [NCH-1:0] clr_en;
  wire [NCH-1:0] stop_en;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      assign irq_en[ch] = act_bit(action_ff, ch, `PMTC_ACT_IRQ_OFS);
      assign clr_en[ch] = act_bit(action_ff, ch, `PMTC_ACT_CLEAR_OFS);
      assign stop_en[ch] = act_bit(action_ff, ch, `PMTC_ACT_STOP_OFS);

      pmtc_compare #(
        .W(W)
      ) u_cmp (
        .clk(clk),
        .rst(rst),
        .main_counter(counter_ff),
        .cmp_value(cmp_value_ff[ch]),
        .hit(hit[ch]),
        .hit_event(hit_event[ch])
      );
    end
  endgenerate

  wire [NCH-1:0] flag_set = hit_event & irq_en;
  wire stop_hit = |(hit_event & stop_en);
  wire clear_hit = |(hit & clr_en);
  wire clearing = run_ff[`PMTC_RUN_COUNT_CLEAR];
  wire count_en = run_ff[`PMTC_RUN_COUNT_RUN] & ~stop_hit;

  // ****************************************************************
  // Divider tally
  // ****************************************************************
  wire [W-1:0] tally;
  wire tick;

  pmtc_divider #(
    .W(W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .count_en(count_en),
    .clear(clearing),
    .divider_limit(limit_ff),
    .wr_en(wr_tally),
    .wr_data(reg_wr_data[W-1:0]),
    .divider_tally(tally),
    .tick(tick)
  );

  // ****************************************************************
  // Main counter
  // ****************************************************************
  always @* begin
    nxt_counter = counter_ff;
    if (clearing) begin
      nxt_counter = {W{1'b0}};
    end else if (wr_counter) begin
      nxt_counter = reg_wr_data[W-1:0];
    end else if (tick) begin
      if (clear_hit) begin
        nxt_counter = {W{1'b0}};
      end else begin
        nxt_counter = counter_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // Run control
  // ****************************************************************
  always @* begin
    nxt_run = run_ff;
    if (wr_run) begin
      nxt_run = reg_wr_data[1:0];
    end
    if (stop_hit) begin
      nxt_run[`PMTC_RUN_COUNT_RUN] = 1'b0;
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  always @* begin
    nxt_flag = flag_ff;
    if (wr_flag) begin
      nxt_flag = flag_ff & ~reg_wr_data[3:0];
    end
    nxt_flag = nxt_flag | flag_set;
  end

  // ****************************************************************
  // Event flag flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      flag_ff <= `PMTC_RST_EVENT_FLAG;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ****************************************************************
  // Run control flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      run_ff <= `PMTC_RST_RUN_CONTROL;
    end else begin
      run_ff <= nxt_run;
    end
  end

  // ****************************************************************
  // Main counter flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      counter_ff <= `PMTC_RST_COUNTER;
    end else begin
      counter_ff <= nxt_counter;
    end
  end

  // ****************************************************************
  // Divider limit and compare action flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      limit_ff <= `PMTC_RST_COUNTER;
      action_ff <= `PMTC_RST_COMPARE_ACTION;
    end else begin
      if (wr_limit) begin
        limit_ff <= reg_wr_data[W-1:0];
      end
      if (wr_action) begin
        action_ff <= reg_wr_data[`PMTC_ACT_USED_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Compare value flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    for (k = 0; k < NCH; k = k + 1) begin
      if (rst) begin
        cmp_value_ff[k] <= `PMTC_RST_COUNTER;
      end else if (reg_wr_en & addr_is(reg_addr, `PMTC_ADDR_CMP0_VALUE + 32'h4 * k)) begin
        cmp_value_ff[k] <= reg_wr_data[W-1:0];
      end
    end
  end

  // ****************************************************************
  // Read data flip-flops
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= 32'h0000_0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @* begin
    nxt_rd_data = rd_data_ff;
    if (reg_rd_en) begin
      case (reg_addr)
        `PMTC_ADDR_EVENT_FLAG: nxt_rd_data = {28'h0000000, flag_ff};
        `PMTC_ADDR_RUN_CONTROL: nxt_rd_data = {30'h0, run_ff};
        `PMTC_ADDR_MAIN_COUNTER: nxt_rd_data = zext(counter_ff);
        `PMTC_ADDR_DIVIDER_LIMIT: nxt_rd_data = zext(limit_ff);
        `PMTC_ADDR_DIVIDER_TALLY: nxt_rd_data = zext(tally);
        `PMTC_ADDR_COMPARE_ACTION: nxt_rd_data = {20'h00000, action_ff};
        `PMTC_ADDR_CMP0_VALUE: nxt_rd_data = zext(cmp_value_ff[0]);
        `PMTC_ADDR_CMP1_VALUE: nxt_rd_data = zext(cmp_value_ff[1]);
        `PMTC_ADDR_CMP2_VALUE: nxt_rd_data = zext(cmp_value_ff[2]);
        `PMTC_ADDR_CMP3_VALUE: nxt_rd_data = zext(cmp_value_ff[3]);
        default: nxt_rd_data = 32'h0000_0000;
      endcase
    end
  end

  assign reg_rd_data = rd_data_ff;
  assign event_flags = flag_ff;
  assign count_running = run_ff[`PMTC_RUN_COUNT_RUN];

endmodule // pmtc_core

// ==== pmtc_regs.vh ====
/*
 * Register addresses, field positions and reset values of the prescaled match timer core.
 * Assumes that it is included by bare name into each file of the block that uses its macros.
 */
`ifndef PMTC_REGS_VH
`define PMTC_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PMTC_ADDR_EVENT_FLAG 32'h4000_4000
`define PMTC_ADDR_RUN_CONTROL 32'h4000_4004
`define PMTC_ADDR_MAIN_COUNTER 32'h4000_4008
`define PMTC_ADDR_DIVIDER_LIMIT 32'h4000_400c
`define PMTC_ADDR_DIVIDER_TALLY 32'h4001_4010
`define PMTC_ADDR_COMPARE_ACTION 32'h4000_4014
`define PMTC_ADDR_CMP0_VALUE 32'h4000_4018
`define PMTC_ADDR_CMP1_VALUE 32'h4000_401c
`define PMTC_ADDR_CMP2_VALUE 32'h4000_4020
`define PMTC_ADDR_CMP3_VALUE 32'h4000_4024

// ****************************************************************
// Field positions
// ****************************************************************
`define PMTC_RUN_COUNT_RUN 0
`define PMTC_RUN_COUNT_CLEAR 1
`define PMTC_ACT_IRQ_OFS 0
`define PMTC_ACT_CLEAR_OFS 1
`define PMTC_ACT_STOP_OFS 2
`define PMTC_ACT_STRIDE 3
`define PMTC_NUM_CHAN 4
`define PMTC_ACT_USED_W 12

// ****************************************************************
// Reset values
// ****************************************************************
`define PMTC_RST_EVENT_FLAG 4'h0
`define PMTC_RST_RUN_CONTROL 2'h0
`define PMTC_RST_COUNTER 32'h0000_0000
`define PMTC_RST_COMPARE_ACTION 12'h000

`endif

// ==== pmtc_divider.v ====
/*
 * Divider tally of the prescaled match timer core.
 * Assumes a single clock and a synchronous active-high reset shared with the core.
 */
`timescale 1ns/1ns
`include "pmtc_regs.vh"

module pmtc_divider #(
  parameter W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire count_en,
  input wire clear,
  input wire [W-1:0] divider_limit,
  // Software access
  input wire wr_en,
  input wire [W-1:0] wr_data,
  // State
  output wire [W-1:0] divider_tally,
  output wire tick
);

  reg [W-1:0] tally_ff;
  reg [W-1:0] nxt_tally;

  // ****************************************************************
  // Terminal count
  // ****************************************************************
  assign tick = count_en & ~clear & (tally_ff == divider_limit);
  assign divider_tally = tally_ff;

  // ****************************************************************
  // Tally update
  // ****************************************************************
  always @* begin
    nxt_tally = tally_ff;
    if (clear) begin
      nxt_tally = {W{1'b0}};
    end else if (wr_en) begin
      nxt_tally = wr_data;
    end else if (count_en) begin
      if (tick) begin
        nxt_tally = {W{1'b0}};
      end else begin
        nxt_tally = tally_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tally_ff <= `PMTC_RST_COUNTER;
    end else begin
      tally_ff <= nxt_tally;
    end
  end

endmodule // pmtc_divider

// ==== pmtc_compare.v ====
/*
 * One compare channel of the prescaled match timer core.
 * Assumes a single clock and a synchronous active-high reset shared with the core.
 */
`timescale 1ns/1ns

module pmtc_compare #(
  parameter W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Compare inputs
  input wire [W-1:0] main_counter,
  input wire [W-1:0] cmp_value,
  // Results
  output wire hit,
  output wire hit_event
);

  reg hit_prev_ff;

  // ****************************************************************
  // Equality and new-hit detection
  // ****************************************************************
  assign hit = (main_counter == cmp_value);
  assign hit_event = hit & ~hit_prev_ff;

  always @(posedge clk) begin
    if (rst) begin
      hit_prev_ff <= 1'b1;
    end else begin
      hit_prev_ff <= hit;
    end
  end

endmodule // pmtc_compare

// ==== pmtc_monitor.sv ====
/*
 * Port checker for pmtc_core.
 * Assumes it is bound to pmtc_core, with one clock and synchronous reset.
 */
`timescale 1ns/1ns
`include "pmtc_regs.vh"

module pmtc_monitor (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [31:0] reg_addr,
  input wire reg_wr_en,
  input wire [31:0] reg_wr_data,
  input wire reg_rd_en,
  input wire [31:0] reg_rd_data,
  // Status
  input wire [3:0] event_flags,
  input wire count_running
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  wire flag_wr = reg_wr_en && reg_addr == `PMTC_ADDR_EVENT_FLAG;
  wire run_wr = reg_wr_en && reg_addr == `PMTC_ADDR_RUN_CONTROL;
  wire run_rd = reg_rd_en && reg_addr == `PMTC_ADDR_RUN_CONTROL;
  wire flag_rd = reg_rd_en && reg_addr == `PMTC_ADDR_EVENT_FLAG;
  wire [3:0] clr_mask = flag_wr ? reg_wr_data[3:0] : 4'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reset_clears_all: assert property (disable iff (1'b0) rst |=> event_flags == 4'h0 &&
    !count_running && reg_rd_data == 32'h0) else $error("State not cleared by reset.");
  a_flag_no_drop: assert property ((~event_flags & $past(event_flags)
    & ~$past(clr_mask)) == 4'h0) else $error("Flag fell without a one written.");
  a_run_rise_cause: assert property ($rose(count_running) |->
    $past(run_wr && reg_wr_data[0])) else $error("Run bit rose without a write.");
  a_run_write_off: assert property (run_wr && !reg_wr_data[0] |=> !count_running)
    else $error("Run bit still set after write of zero.");
  a_run_read_value: assert property (run_rd |=> reg_rd_data[31:2] == 30'h0 &&
    reg_rd_data[0] == $past(count_running)) else $error("Run control read wrong.");
  a_flag_read_value: assert property (flag_rd |=>
    reg_rd_data == {28'h0, $past(event_flags)}) else $error("Flag read wrong.");
  a_action_rsvd_zero: assert property (reg_rd_en && reg_addr == `PMTC_ADDR_COMPARE_ACTION
    |=> reg_rd_data[31:12] == 20'h0) else $error("Reserved action bits not zero.");
  a_unmapped_zero: assert property (reg_rd_en && reg_addr == 32'h4000_4028
    |=> reg_rd_data == 32'h0) else $error("Unmapped read not zero.");
endmodule // pmtc_monitor

bind pmtc_core pmtc_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .event_flags(event_flags), .count_running(count_running));

// ==== prescaled_match_timer_core_tb.sv ====
/*
 * Self-checking bench for pmtc_core.
 * Assumes the one-cycle strobe register port of the core.
 */
`timescale 1ns/1ns
`include "pmtc_regs.vh"

module prescaled_match_timer_core_tb;
  localparam [31:0] A_FLG = `PMTC_ADDR_EVENT_FLAG;
  localparam [31:0] A_RUN = `PMTC_ADDR_RUN_CONTROL;
  localparam [31:0] A_CNT = `PMTC_ADDR_MAIN_COUNTER;
  localparam [31:0] A_LIM = `PMTC_ADDR_DIVIDER_LIMIT;
  localparam [31:0] A_TAL = `PMTC_ADDR_DIVIDER_TALLY;
  localparam [31:0] A_ACT = `PMTC_ADDR_COMPARE_ACTION;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] reg_addr = 32'h0;
  reg reg_wr_en = 1'b0;
  reg [31:0] reg_wr_data = 32'h0;
  reg reg_rd_en = 1'b0;
  wire [31:0] reg_rd_data;
  wire [3:0] event_flags;
  wire count_running;
  integer failures = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer i;

  pmtc_core DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .event_flags(event_flags), .count_running(count_running));

  always #5 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task print_verdict;
    begin
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
    end
  endtask

  task rd(input [31:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1;
      chk(reg_rd_data, exp);
    end
  endtask

  // Counts for m + 2 clock edges from where the counters stand.
  task go(input integer m);
    begin
      wr(A_RUN, 32'h1);
      repeat (m) @(posedge clk);
      wr(A_RUN, 32'h0);
    end
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles > 3000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(A_FLG, 32'h0);
    rd(A_RUN, 32'h0);
    rd(A_CNT, 32'h0);
    rd(A_LIM, 32'h0);
    rd(A_TAL, 32'h0);
    rd(A_ACT, 32'h0);
    rd(32'h4000_4028, 32'h0);
    wr(A_ACT, 32'hffff_f000);
    rd(A_ACT, 32'h0);
    wr(A_LIM, 32'h5a5a_a5a5);
    rd(A_LIM, 32'h5a5a_a5a5);
    wr(A_TAL, 32'h7);
    rd(A_TAL, 32'h7);
    for (i = 0; i < 3; i = i + 1) begin
      wr(A_LIM, i);
      wr(A_RUN, 32'h2);
      go(8);
      rd(A_CNT, 10 / (i + 1));
      rd(A_TAL, 10 % (i + 1));
    end
    wr(A_RUN, 32'h3);
    repeat (4) @(posedge clk);
    chk({31'h0, count_running}, 32'h1);
    rd(A_CNT, 32'h0);
    rd(A_TAL, 32'h0);
    wr(A_RUN, 32'h0);
    wr(A_LIM, 32'h0);
    wr(A_CNT, 32'hffff_ffff);
    go(2);
    rd(A_CNT, 32'h3);
    rd(A_FLG, 32'h0);
    wr(`PMTC_ADDR_CMP1_VALUE, 32'h5);
    wr(A_ACT, 32'h28);
    wr(A_RUN, 32'h2);
    wr(A_RUN, 32'h1);
    repeat (20) @(posedge clk);
    chk({31'h0, count_running}, 32'h0);
    chk({28'h0, event_flags}, 32'h2);
    rd(A_CNT, 32'h5);
    rd(A_TAL, 32'h0);
    wr(A_FLG, 32'hd);
    rd(A_FLG, 32'h2);
    wr(A_FLG, 32'h2);
    rd(A_FLG, 32'h0);
    wr(`PMTC_ADDR_CMP2_VALUE, 32'h3);
    wr(A_LIM, 32'h1);
    wr(A_ACT, 32'hc0);
    wr(A_RUN, 32'h2);
    go(20);
    rd(A_CNT, 32'h3);
    rd(A_FLG, 32'h4);
    wr(A_ACT, 32'h200);
    wr(A_FLG, 32'h4);
    wr(A_LIM, 32'h0);
    wr(`PMTC_ADDR_CMP3_VALUE, 32'h4);
    wr(A_RUN, 32'h2);
    wr(A_RUN, 32'h1);
    repeat (4) @(posedge clk);
    #1;
    chk({28'h0, event_flags}, 32'h0);
    @(posedge clk);
    #1;
    chk({28'h0, event_flags}, 32'h8);
    wr(A_RUN, 32'h0);
    rd(A_CNT, 32'h7);
    rd(A_FLG, 32'h8);
    print_verdict;
  end
endmodule // prescaled_match_timer_core_tb
